// ===== pkg/pmrc_pkg.sv
/*
  Package for the power mode and reset control block: register map,
  field positions, reset values, timing counts and sequencer states.
  Assumes a 100 MHz pclk and an APB master with 32-bit data.
*/
package pmrc_pkg;
  // Register byte addresses
  localparam logic [7:0] pmrc_addr_mode = 8'h20;
  localparam logic [7:0] pmrc_addr_status = 8'h24;
  localparam logic [7:0] pmrc_addr_wake_en = 8'h28;
  localparam logic [7:0] pmrc_addr_cause = 8'h2c;
  // Field positions
  localparam int pmrc_bit_low_clock_select = 0;
  localparam int pmrc_bit_rtc_fast_startup = 4;
  localparam int pmrc_bit_power_down_flag = 0;
  localparam int pmrc_bit_watchdog_timeout_flag = 1;
  localparam logic [7:0] pmrc_mode_mask = 8'h11;
  // Reset values of the core registers that a chip reset initialises
  localparam logic [7:0] pmrc_rst_mode = 8'h00;
  localparam logic [7:0] pmrc_rst_port = 8'hff;
  localparam logic [7:0] pmrc_rst_port_c = 8'h00;
  localparam logic [7:0] pmrc_rst_timer0_control = 8'h08;
  localparam logic [7:0] pmrc_rst_timer1_control = 8'h08;
  localparam logic [7:0] pmrc_rst_interrupt_control = 8'h00;
  localparam logic [7:0] pmrc_rst_wake_en = 8'h00;
  // Timing
  localparam int pmrc_startup_periods = 1024;
  localparam int pmrc_option_load_ns = 1000;
  localparam int pmrc_clk_period_ns = 10;
  localparam int pmrc_option_load_cycles =
    (pmrc_option_load_ns + pmrc_clk_period_ns - 1) / pmrc_clk_period_ns;
  // Reset cause codes
  localparam logic [2:0] pmrc_cause_power_up = 3'h0;
  localparam logic [2:0] pmrc_cause_ext_normal = 3'h1;
  localparam logic [2:0] pmrc_cause_ext_halt = 3'h2;
  localparam logic [2:0] pmrc_cause_wdt_normal = 3'h3;
  localparam logic [2:0] pmrc_cause_wdt_halt = 3'h4;
  localparam logic [2:0] pmrc_cause_wake = 3'h5;
  typedef enum logic [2:0] {
    pmrc_st_option = 3'b000,
    pmrc_st_startup = 3'b001,
    pmrc_st_run = 3'b011,
    pmrc_st_halt = 3'b010
  } pmrc_state_t;
endpackage

// ===== hdl/pmrc_sync.sv
/*
  Two-flop synchroniser, one per bit.
  Assumes inputs from outside the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pmrc_sync #(
  parameter int width = 1,
  parameter logic [width-1:0] init = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= init;
      sync_out <= init;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/pmrc_delay_timer.sv
/*
  Down counter for the option load and start-up delays.
  Assumes load is a one-cycle pulse; done pulses when the count expires.
*/
`timescale 1ns/1ps
`default_nettype none
module pmrc_delay_timer #(
  parameter int width = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [width-1:0] load_value,
  output logic busy,
  output logic done
);
  logic [width-1:0] count;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        count <= load_value;
        busy <= 1'b1;
      end else if (busy) begin
        if (count <= width'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - width'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/pmrc_top.sv
/*
  Power mode and reset control: clock select, normal/slow/idle modes,
  halt entry and wake-up, reset sequencing and reset-cause flags.
  Assumes the core gives one-cycle pulses for halt and watchdog clear
  and honours cpu_run, warm_reset and the reset outputs; pins and the
  watchdog overflow arrive asynchronously.
*/
// Contract
// - Clock select 0 runs from RC/crystal, 1 runs from 32768Hz and stops RC.
// - Mode bit 4 chooses quick (0) or slow (1) RTC oscillator start-up.
// - Mode bits 1-3 and 5-7 are unused and read zero.
// - Normal: RC on; slow: RC off; idle: RC off, 32768Hz on.
// - Halt stops the system oscillator; watchdog runs only on its own oscillator.
// - Halt and power-down keep RAM, registers and port states.
// - Halt clears the watchdog counter.
// - Halt sets the power-down flag and clears the timeout flag.
// - Halt ends on external reset, interrupt, port A falling edge, watchdog overflow.
// - External reset in halt fully initialises; watchdog overflow warm-resets.
// - Warm reset clears only program counter and stack pointer.
// - Power-down flag: cleared by power-up or watchdog clear, set by halt.
// - Port A wake-up enabled per pin; resumes after the halt.
// - Interrupt wake vectors if enabled and stack not full, else resumes.
// - A request already pending at halt entry cannot wake that halt.
// - Every reset and wake-up waits 1024 system clocks before execution.
// - Power-up, normal watchdog reset and external reset add option load delay.
// - Flags encode cause: 00 power-up, 01 external halt wake, 11 watchdog halt wake.
// - Chip reset: PC 000H, interrupts off, watchdog cleared, ports input.
// - Non-warm resets load port, timer, interrupt and mode reset values.
// - RTC oscillator keeps running through halt when enabled.
`timescale 1ns/1ps
`default_nettype none
module pmrc_top
  import pmrc_pkg::*;
#(
  parameter int startup_cycles = pmrc_startup_periods,
  parameter int option_cycles = pmrc_option_load_cycles,
  parameter int porta_width = 8,
  parameter int irq_width = 3,
  parameter logic [porta_width-1:0] porta_wake_default = '0,
  parameter bit wdt_on_own_osc = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic [porta_width-1:0] port_a_pin,
  input wire logic [irq_width-1:0] irq_request,
  input wire logic [irq_width-1:0] irq_enable,
  input wire logic irq_master_enable,
  input wire logic stack_full,
  input wire logic watchdog_overflow,
  input wire logic halt_instruction,
  input wire logic watchdog_clear_instruction,
  input wire logic rtc_enable,
  output logic cpu_run,
  output logic chip_reset,
  output logic warm_reset,
  output logic watchdog_clear,
  output logic watchdog_run,
  output logic interrupt_vector_take,
  output logic rc_osc_enable,
  output logic rtc_osc_enable,
  output logic sys_clock_is_rtc,
  output logic rtc_fast_startup,
  output logic power_down_flag,
  output logic watchdog_timeout_flag,
  output logic [7:0] port_a_data,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_data,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_data,
  output logic [7:0] timer0_control,
  output logic [7:0] timer1_control,
  output logic [7:0] interrupt_control_register
);
  localparam int tw = 16;

  pmrc_state_t state;
  pmrc_state_t next_state;
  logic [7:0] clock_mode_control;
  logic [porta_width-1:0] porta_wake_en;
  logic [2:0] reset_cause;
  logic [irq_width-1:0] irq_blocked;
  logic [porta_width-1:0] porta_prev;
  logic ext_prev_n;
  logic wdt_prev;
  logic vector_pending;

  logic ext_rst_n_s;
  logic wdt_s;
  logic [porta_width-1:0] porta_s;
  pmrc_sync #(.width(1), .init(1'b1)) u_sync_rst (
    .pclk(pclk), .presetn(presetn), .async_in(external_reset_pin_n), .sync_out(ext_rst_n_s));
  pmrc_sync #(.width(1), .init(1'b0)) u_sync_wdt (
    .pclk(pclk), .presetn(presetn), .async_in(watchdog_overflow), .sync_out(wdt_s));
  pmrc_sync #(.width(porta_width), .init({porta_width{1'b1}})) u_sync_pa (
    .pclk(pclk), .presetn(presetn), .async_in(port_a_pin), .sync_out(porta_s));

  // Events, edge-detected after synchronisation
  wire ext_reset_evt = ext_prev_n & ~ext_rst_n_s;
  wire wdt_evt = wdt_s & ~wdt_prev;
  wire [porta_width-1:0] porta_fall = porta_prev & ~porta_s;
  wire porta_wake = |(porta_fall & porta_wake_en);
  // Stale requests are masked so they cannot end this halt
  wire irq_wake = |(irq_request & ~irq_blocked);
  wire irq_vectors = irq_master_enable & |(irq_request & irq_enable & ~irq_blocked) & ~stack_full;
  wire in_halt = (state == pmrc_st_halt);
  wire halt_go = (state == pmrc_st_run) & halt_instruction;
  wire wdt_warm = in_halt & wdt_evt;
  wire wdt_chip = ~in_halt & wdt_evt;
  wire wake_evt = in_halt & (irq_wake | porta_wake) & ~ext_reset_evt & ~wdt_evt;
  // Full reset paths go through option load; warm and wake only through start-up
  wire full_reset = ext_reset_evt | wdt_chip;
  wire short_start = wdt_warm | wake_evt;

  logic opt_load;
  logic opt_busy;
  logic opt_done;
  logic sst_load;
  logic sst_busy;
  logic sst_done;
  assign opt_load = full_reset;
  pmrc_delay_timer #(.width(tw)) u_option_timer (
    .pclk(pclk), .presetn(presetn), .load(opt_load), .load_value(tw'(option_cycles)),
    .busy(opt_busy), .done(opt_done));
  pmrc_delay_timer #(.width(tw)) u_startup_timer (
    .pclk(pclk), .presetn(presetn), .load(sst_load), .load_value(tw'(startup_cycles)),
    .busy(sst_busy), .done(sst_done));

  // Power-up leaves the option-load state once the power-up option count reaches zero
  logic por_pending;
  always_comb begin
    next_state = state;
    case (state)
      pmrc_st_option: begin
        if (opt_done | por_pending) begin
          next_state = pmrc_st_startup;
        end
      end
      pmrc_st_startup: begin
        if (full_reset) begin
          next_state = pmrc_st_option;
        end else if (sst_done) begin
          next_state = pmrc_st_run;
        end
      end
      pmrc_st_run: begin
        if (full_reset) begin
          next_state = pmrc_st_option;
        end else if (halt_instruction) begin
          next_state = pmrc_st_halt;
        end
      end
      pmrc_st_halt: begin
        if (ext_reset_evt) begin
          next_state = pmrc_st_option;
        end else if (short_start) begin
          next_state = pmrc_st_startup;
        end
      end
      default: begin
        next_state = pmrc_st_option;
      end
    endcase
  end

  // Power-up option load: runs from release before start-up
  logic por_opt_busy;
  logic [tw-1:0] por_count;
  assign por_pending = por_opt_busy & (por_count == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_opt_busy <= 1'b1;
      por_count <= tw'(option_cycles);
    end else if (por_opt_busy) begin
      if (por_count == '0) begin
        por_opt_busy <= 1'b0;
      end else begin
        por_count <= por_count - tw'(1);
      end
    end
  end

  // Power-up start-up load is driven by the por sequence ending
  logic sst_por_kick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pmrc_st_option;
      sst_por_kick <= 1'b0;
    end else begin
      state <= next_state;
      sst_por_kick <= por_pending;
    end
  end

  // APB decode; single-cycle access, no wait states
  wire apb_access = psel & penable;
  wire apb_wr = apb_access & pwrite;
  wire hit_mode = (paddr == pmrc_addr_mode);
  wire hit_status = (paddr == pmrc_addr_status);
  wire hit_wake = (paddr == pmrc_addr_wake_en);
  wire hit_cause = (paddr == pmrc_addr_cause);
  wire hit_any = hit_mode | hit_status | hit_wake | hit_cause;
  logic [31:0] read_mux;
  always_comb begin
    if (hit_mode) begin
      read_mux = {24'h0, clock_mode_control & pmrc_mode_mask};
    end else if (hit_status) begin
      read_mux = {30'h0, watchdog_timeout_flag, power_down_flag};
    end else if (hit_wake) begin
      read_mux = 32'(porta_wake_en);
    end else if (hit_cause) begin
      read_mux = {29'h0, reset_cause};
    end else begin
      read_mux = 32'h0;
    end
  end

  // Registers touched by a full reset; warm reset leaves them alone
  wire init_regs = full_reset;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_mode_control <= pmrc_rst_mode;
      porta_wake_en <= porta_wake_default;
      port_a_data <= pmrc_rst_port;
      port_a_direction <= pmrc_rst_port;
      port_b_data <= pmrc_rst_port;
      port_b_direction <= pmrc_rst_port;
      port_c_data <= pmrc_rst_port_c;
      timer0_control <= pmrc_rst_timer0_control;
      timer1_control <= pmrc_rst_timer1_control;
      interrupt_control_register <= pmrc_rst_interrupt_control;
    end else if (init_regs) begin
      clock_mode_control <= pmrc_rst_mode;
      port_a_data <= pmrc_rst_port;
      port_a_direction <= pmrc_rst_port;
      port_b_data <= pmrc_rst_port;
      port_b_direction <= pmrc_rst_port;
      port_c_data <= pmrc_rst_port_c;
      timer0_control <= pmrc_rst_timer0_control;
      timer1_control <= pmrc_rst_timer1_control;
      interrupt_control_register <= pmrc_rst_interrupt_control;
    end else if (apb_wr & hit_mode) begin
      clock_mode_control <= pwdata[7:0] & pmrc_mode_mask;
    end else if (apb_wr & hit_wake) begin
      porta_wake_en <= pwdata[porta_width-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata <= (psel & ~penable & ~pwrite) ? read_mux : 32'h0;
    end
  end

  // Flags; power-up gives 00, a set wins over a same-cycle clear, except halt entry clears the timeout flag over a watchdog set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_flag <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
      reset_cause <= pmrc_cause_power_up;
    end else begin
      if (halt_go) begin
        power_down_flag <= 1'b1;
        watchdog_timeout_flag <= 1'b0;
      end else if (wdt_evt) begin
        watchdog_timeout_flag <= 1'b1;
      end else if (ext_reset_evt & in_halt) begin
        watchdog_timeout_flag <= 1'b0;
      end else if (watchdog_clear_instruction & (state == pmrc_st_run)) begin
        power_down_flag <= 1'b0;
      end
      if (ext_reset_evt) begin
        reset_cause <= in_halt ? pmrc_cause_ext_halt : pmrc_cause_ext_normal;
      end else if (wdt_evt) begin
        reset_cause <= in_halt ? pmrc_cause_wdt_halt : pmrc_cause_wdt_normal;
      end else if (wake_evt) begin
        reset_cause <= pmrc_cause_wake;
      end
    end
  end

  // Requests pending at halt entry are frozen out for that halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_blocked <= '0;
      porta_prev <= {porta_width{1'b1}};
      ext_prev_n <= 1'b1;
      wdt_prev <= 1'b0;
      vector_pending <= 1'b0;
    end else begin
      porta_prev <= porta_s;
      ext_prev_n <= ext_rst_n_s;
      wdt_prev <= wdt_s;
      if (halt_go) begin
        irq_blocked <= irq_request;
      end else if (!in_halt) begin
        irq_blocked <= '0;
      end
      if (wake_evt) begin
        vector_pending <= irq_vectors;
      end else if (full_reset | wdt_warm | (state == pmrc_st_run)) begin
        vector_pending <= 1'b0;
      end
    end
  end

  // Outputs, all registered
  wire low_clk = clock_mode_control[pmrc_bit_low_clock_select];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_run <= 1'b0;
      chip_reset <= 1'b1;
      warm_reset <= 1'b0;
      watchdog_clear <= 1'b1;
      watchdog_run <= 1'b0;
      interrupt_vector_take <= 1'b0;
      rc_osc_enable <= 1'b1;
      rtc_osc_enable <= 1'b1;
      sys_clock_is_rtc <= 1'b0;
      rtc_fast_startup <= 1'b0;
    end else begin
      // Core stalls, so RAM and ports hold their state in halt
      cpu_run <= (next_state == pmrc_st_run);
      chip_reset <= (next_state == pmrc_st_option) | por_opt_busy;
      warm_reset <= wdt_warm;
      watchdog_clear <= halt_go | full_reset | watchdog_clear_instruction;
      watchdog_run <= (next_state == pmrc_st_halt) ? wdt_on_own_osc : 1'b1;
      interrupt_vector_take <= vector_pending & sst_done;
      rc_osc_enable <= ~low_clk & (next_state != pmrc_st_halt);
      rtc_osc_enable <= rtc_enable | low_clk;
      sys_clock_is_rtc <= low_clk;
      rtc_fast_startup <= ~clock_mode_control[pmrc_bit_rtc_fast_startup];
    end
  end

  // Kick the start-up timer when an option load ends, on a warm or wake start, and once the power-up option load ends
  assign sst_load = opt_done | short_start | sst_por_kick;
  logic sst_busy_unused;
  assign sst_busy_unused = sst_busy | opt_busy;
endmodule
`default_nettype wire

// ===== verification/pmrc_top_properties.sv
/*
  Port checker for pmrc_top.
  Assumes it is bound to pmrc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pmrc_top_properties
  import pmrc_pkg::*;
#(
  parameter int startup_cycles = 8,
  parameter int option_cycles = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic halt_instruction,
  input wire logic watchdog_clear_instruction,
  input wire logic irq_master_enable,
  input wire logic stack_full,
  input wire logic cpu_run,
  input wire logic chip_reset,
  input wire logic warm_reset,
  input wire logic watchdog_clear,
  input wire logic interrupt_vector_take,
  input wire logic rc_osc_enable,
  input wire logic sys_clock_is_rtc,
  input wire logic rtc_fast_startup,
  input wire logic power_down_flag,
  input wire logic watchdog_timeout_flag,
  input wire logic [7:0] port_a_data,
  input wire logic [7:0] port_a_direction,
  input wire logic [7:0] port_b_data,
  input wire logic [7:0] port_c_data,
  input wire logic [7:0] timer0_control,
  input wire logic [7:0] timer1_control
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned low_cnt;
  int unsigned rst_cnt;
  logic lw0;
  logic lw4;
  wire mode_wr = psel && penable && pready && pwrite && paddr == pmrc_addr_mode;
  // Counters span whole delays, far beyond a repetition's reach
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 0;
      rst_cnt <= 0;
      lw0 <= 1'b0;
      lw4 <= 1'b0;
    end else begin
      low_cnt <= (chip_reset || cpu_run) ? 0 : low_cnt + 1;
      rst_cnt <= chip_reset ? rst_cnt + 1 : 0;
      if (mode_wr) begin
        lw0 <= pwdata[0];
        lw4 <= pwdata[4];
      end
    end
  end
  chk_clock_select: assert property (mode_wr |=> ##[0:1] sys_clock_is_rtc == lw0)
    else $error("clock select does not follow mode bit 0");
  chk_rc_stopped: assert property (sys_clock_is_rtc |-> !rc_osc_enable)
    else $error("RC oscillator runs on the slow clock");
  chk_rtc_startup: assert property (mode_wr |=> ##[0:1] rtc_fast_startup == !lw4)
    else $error("RTC start-up speed does not follow mode bit 4");
  chk_mode_unused: assert property (pready && !pwrite && paddr == pmrc_addr_mode |-> (prdata & ~32'h11) == 0)
    else $error("unused mode bits read nonzero");
  chk_halt_entry: assert property (halt_instruction && cpu_run |=> !cpu_run && !rc_osc_enable && watchdog_clear
      && power_down_flag && !watchdog_timeout_flag)
    else $error("halt entry effects missing");
  chk_pdf_clear: assert property (watchdog_clear_instruction && cpu_run && !halt_instruction |=> !power_down_flag)
    else $error("watchdog clear left the power-down flag set");
  chk_warm_keep: assert property (warm_reset |-> !chip_reset ##1 $stable(port_a_data) && $stable(port_a_direction)
      && $stable(timer0_control) && $stable(timer1_control))
    else $error("warm reset disturbed registers");
  chk_warm_flags: assert property (warm_reset |-> ##[0:1] watchdog_timeout_flag && power_down_flag)
    else $error("warm reset flags not 11");
  chk_startup_len: assert property ($rose(cpu_run) |-> low_cnt >= startup_cycles - 1)
    else $error("execution resumed before the start-up delay");
  chk_option_len: assert property ($fell(chip_reset) |-> rst_cnt >= option_cycles - 1)
    else $error("option load delay too short");
  chk_chip_values: assert property ($fell(chip_reset) |-> port_a_data == pmrc_rst_port && port_c_data == pmrc_rst_port_c
      && port_b_data == pmrc_rst_port && timer0_control == pmrc_rst_timer0_control
      && timer1_control == pmrc_rst_timer1_control)
    else $error("chip reset values wrong");
  chk_ports_hold: assert property (!cpu_run && !chip_reset |=> $stable(port_a_data) && $stable(port_a_direction))
    else $error("ports changed while stopped");
  chk_vector_ok: assert property (interrupt_vector_take |-> irq_master_enable && !stack_full)
    else $error("vectoring with interrupts blocked");
endmodule
bind pmrc_top pmrc_top_properties #(.startup_cycles(startup_cycles), .option_cycles(option_cycles)) i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .halt_instruction,
  .watchdog_clear_instruction, .irq_master_enable, .stack_full, .cpu_run, .chip_reset, .warm_reset,
  .watchdog_clear, .interrupt_vector_take, .rc_osc_enable, .sys_clock_is_rtc, .rtc_fast_startup,
  .power_down_flag, .watchdog_timeout_flag, .port_a_data, .port_a_direction, .port_b_data, .port_c_data,
  .timer0_control, .timer1_control);
`default_nettype wire

// ===== verification/pmrc_core_model.sv
/*
  Core model: issues halt and watchdog clear instruction pulses.
  Assumes pmrc_top drives cpu_run; one request at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module pmrc_core_model (
  input wire logic pclk,
  input wire logic cpu_run,
  output logic halt_instruction,
  output logic watchdog_clear_instruction
);
  initial begin
    halt_instruction = 1'b0;
    watchdog_clear_instruction = 1'b0;
  end
  // A stopped core executes nothing, so wait for cpu_run
  task automatic issue(input bit halt);
    while (cpu_run !== 1'b1) @(posedge pclk);
    if (halt) halt_instruction <= 1'b1;
    else watchdog_clear_instruction <= 1'b1;
    @(posedge pclk);
    halt_instruction <= 1'b0;
    watchdog_clear_instruction <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_pmrc_top.sv
/*
  Self-checking bench for pmrc_top with a core model.
  Assumes short start-up and option counts for simulation.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_pmrc_top;
  import pmrc_pkg::*;
  localparam int st = 8;
  localparam int opt = 4;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, ext_n, wdt_ovf, sf, mie, took;
  logic [7:0] paddr, pa, prt, m;
  logic [31:0] pwdata, prdata, v;
  logic [2:0] irq, ien;
  logic halt_i, clr_i, cpu_run, take, rc_en, rtc_en, wdt_run, vsel;
  int bad_count, cmp_count, n;
  pmrc_core_model i_core (.pclk(pclk), .cpu_run(cpu_run), .halt_instruction(halt_i),
    .watchdog_clear_instruction(clr_i));
  // Watchdog clocked from 32768Hz, so the slow clock is legal
  pmrc_top #(.startup_cycles(st), .option_cycles(opt), .wdt_on_own_osc(1'b0)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_reset_pin_n(ext_n),
    .port_a_pin(pa), .irq_request(irq), .irq_enable(ien), .irq_master_enable(mie), .stack_full(sf),
    .watchdog_overflow(wdt_ovf), .halt_instruction(halt_i), .watchdog_clear_instruction(clr_i),
    .rtc_enable(1'b1), .cpu_run(cpu_run), .chip_reset(), .warm_reset(), .watchdog_clear(),
    .watchdog_run(wdt_run), .interrupt_vector_take(take), .rc_osc_enable(rc_en), .rtc_osc_enable(rtc_en),
    .sys_clock_is_rtc(vsel), .rtc_fast_startup(), .power_down_flag(), .watchdog_timeout_flag(),
    .port_a_data(prt), .port_a_direction(), .port_b_data(), .port_b_direction(), .port_c_data(),
    .timer0_control(), .timer1_control(), .interrupt_control_register());
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (take === 1'b1) took <= 1'b1;
  function automatic logic [31:0] mode_exp(input logic [31:0] d);
    return d & 32'h11;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    v = w ? 32'(pslverr) : prdata;
    if (k >= 20) chk("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, v);
  endtask
  task automatic wait_run(input int pre);
    repeat (pre) @(posedge pclk);
    n = 0;
    while (cpu_run !== 1'b1 && n < 2000) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 2000) chk("run_wait", 1, 0);
  endtask
  task automatic halt_now;
    i_core.issue(1'b1);
    repeat (2) @(posedge pclk);
    chk("halt_osc", 3'b010, {rc_en, rtc_en, wdt_run});
    rd(pmrc_addr_status, 32'h1, "status_halt");
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #500000;
    chk("watchdog", 1, 0);
    test_done;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, wdt_ovf, sf, mie, irq, ien, took} = '0;
    ext_n = 1'b1;
    pa = 8'hff;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(32'h73217acb));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_run(0);
    chk("startup_len", 1, n >= opt + st);
    rd(pmrc_addr_mode, 32'h0, "mode_reset");
    rd(pmrc_addr_cause, pmrc_cause_power_up, "cause_pwrup");
    rd(pmrc_addr_status, 32'h0, "status_pwrup");
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      apb(1'b1, pmrc_addr_mode, {24'($urandom), m});
      rd(pmrc_addr_mode, mode_exp(m), "mode_rb");
      chk("clock_sel", {m[0], ~m[0]}, {vsel, rc_en});
    end
    apb(1'b1, pmrc_addr_mode, 32'h0);
    apb(1'b1, 8'h30, 32'hffffffff);
    chk("unmapped_err", 1, pslverr_seen());
    m = 8'($urandom) & 8'h7e | 8'h01;
    apb(1'b1, pmrc_addr_wake_en, m);
    rd(pmrc_addr_wake_en, m, "wake_en");
    halt_now;
    pa[7] <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("no_wake_off_pin", 0, cpu_run);
    pa[0] <= 1'b0;
    wait_run(4);
    pa <= 8'hff;
    rd(pmrc_addr_cause, pmrc_cause_wake, "cause_wake");
    rd(pmrc_addr_status, 32'h1, "status_wake");
    i_core.issue(1'b0);
    rd(pmrc_addr_status, 32'h0, "status_clr");
    ien <= 3'b111;
    mie <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      sf <= s[0];
      took <= 1'b0;
      halt_now;
      irq[1] <= 1'b1;
      wait_run(4);
      repeat (3) @(posedge pclk);
      chk("vector_take", !s[0], took);
      irq <= 3'b000;
      @(posedge pclk);
    end
    apb(1'b1, pmrc_addr_mode, 32'h10);
    irq[2] <= 1'b1;
    halt_now;
    repeat (10) @(posedge pclk);
    chk("pending_no_wake", 0, cpu_run);
    wdt_ovf <= 1'b1;
    wait_run(4);
    wdt_ovf <= 1'b0;
    irq <= 3'b000;
    rd(pmrc_addr_status, 32'h3, "status_wdt_halt");
    rd(pmrc_addr_cause, pmrc_cause_wdt_halt, "cause_wdt_halt");
    rd(pmrc_addr_mode, 32'h10, "mode_warm");
    halt_now;
    ext_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_n <= 1'b1;
    wait_run(2);
    rd(pmrc_addr_status, 32'h1, "status_ext_halt");
    rd(pmrc_addr_cause, pmrc_cause_ext_halt, "cause_ext_halt");
    rd(pmrc_addr_mode, 32'h0, "mode_ext_halt");
    chk("port_reset", pmrc_rst_port, prt);
    i_core.issue(1'b0);
    apb(1'b1, pmrc_addr_mode, 32'h10);
    wdt_ovf <= 1'b1;
    wait_run(6);
    wdt_ovf <= 1'b0;
    rd(pmrc_addr_status, 32'h2, "status_wdt_run");
    rd(pmrc_addr_cause, pmrc_cause_wdt_normal, "cause_wdt_run");
    rd(pmrc_addr_mode, 32'h0, "mode_wdt_run");
    ext_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_n <= 1'b1;
    wait_run(2);
    rd(pmrc_addr_status, 32'h2, "status_ext_run");
    rd(pmrc_addr_cause, pmrc_cause_ext_normal, "cause_ext_run");
    test_done;
  end
  function automatic logic pslverr_seen();
    return v[0];
  endfunction
endmodule
`default_nettype wire
